// ---- core/dses_cfg.svh ----
`ifndef DSES_CFG_SVH
`define DSES_CFG_SVH

// Event codes carried in the read and write trigger selection fields
`define DSES_CODE_W 5
`define DSES_CODE_NONE 5'h00
`define DSES_CODE_TIMER0 5'h01
`define DSES_CODE_TIMER1 5'h02
`define DSES_CODE_REFRESH 5'h03
`define DSES_CODE_EXT4 5'h04
`define DSES_CODE_EXT5 5'h05
`define DSES_CODE_EXT6 5'h06
`define DSES_CODE_EXT7 5'h07
`define DSES_CODE_DONE0 5'h08
`define DSES_CODE_DONE3 5'h0B
`define DSES_CODE_SER0_TX 5'h0C
`define DSES_CODE_SER0_RX 5'h0D
`define DSES_CODE_SER1_TX 5'h0E
`define DSES_CODE_SER1_RX 5'h0F
`define DSES_CODE_DOORBELL 5'h10
`define DSES_CODE_SER2_TX 5'h11
`define DSES_CODE_SER2_RX 5'h12
`define DSES_CODE_LAST 5'h12

// Number of event sources and channels
`define DSES_NUM_SRC 19
`define DSES_NUM_CHAN 4
`define DSES_SEL_RESET 5'h00

`endif

// ---- core/dses_code_mux.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "dses_cfg.svh"

module dses_code_mux
    import dses_pkg::*;
#(
    parameter int NUM_SRC = `DSES_NUM_SRC
) (
    // Selection and sources
    input wire dses_code_t code,
    input wire logic [NUM_SRC-1:0] events,
    // Selected event
    output logic hit
);

    // The selector can only reach as many sources as the code has values
    if (NUM_SRC < 1 || NUM_SRC > (1 << `DSES_CODE_W)) begin : g_bad_src
        $error("dses_code_mux: NUM_SRC out of range");
    end

    // Codes beyond the source list fall to zero, so reserved codes never trigger
    always_comb begin
        hit = 1'b0;
        if (int'(code) < NUM_SRC) begin
            hit = events[code];
        end
    end

endmodule

`default_nettype wire

// ---- core/dses_pkg.sv ----
`include "dses_cfg.svh"

package dses_pkg;

    typedef logic [`DSES_CODE_W-1:0] dses_code_t;

    // One channel's pair of selections
    typedef struct packed {
        dses_code_t write_trigger_select;
        dses_code_t read_trigger_select;
    } dses_sel_t;

    // Event sources, bit index equals the event code
    typedef struct packed {
        logic serial2_rx_event;
        logic serial2_tx_event;
        logic host_doorbell;
        logic serial1_rx_event;
        logic serial1_tx_event;
        logic serial0_rx_event;
        logic serial0_tx_event;
        logic chan3_done;
        logic chan2_done;
        logic chan1_done;
        logic chan0_done;
        logic ext_irq_pin_seven;
        logic ext_irq_pin_six;
        logic ext_irq_pin_five;
        logic ext_irq_pin_four;
        logic refresh_timer_event;
        logic timer1_expiry;
        logic timer0_expiry;
        logic never_fires;
    } dses_events_t;

    // Trigger pair for one channel
    typedef struct packed {
        logic write_trigger;
        logic read_trigger;
    } dses_trig_t;

endpackage

// ---- core/dses_select.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "dses_cfg.svh"

module dses_select
    import dses_pkg::*;
#(
    parameter int NUM_CHAN = `DSES_NUM_CHAN
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,

    // Selections written into each channel's primary control
    input wire dses_sel_t [NUM_CHAN-1:0] chan_sel,

    // Timer and refresh sources
    input wire logic timer0_expiry,
    input wire logic timer1_expiry,
    input wire logic refresh_timer_event,

    // External interrupt pins
    input wire logic ext_irq_pin_four,
    input wire logic ext_irq_pin_five,
    input wire logic ext_irq_pin_six,
    input wire logic ext_irq_pin_seven,

    // Completions of the transfer channels, so one channel can chain on another
    input wire logic [NUM_CHAN-1:0] chan_done,

    // Serial port events
    input wire logic serial0_tx_event,
    input wire logic serial0_rx_event,
    input wire logic serial1_tx_event,
    input wire logic serial1_rx_event,
    input wire logic serial2_tx_event,
    input wire logic serial2_rx_event,

    // Host doorbell
    input wire logic host_doorbell,

    // Triggers to the transfer engine
    output var dses_trig_t [NUM_CHAN-1:0] chan_trig
);

    // Highest code that names a source; every code above it is reserved
    localparam dses_code_t LAST_CODE = `DSES_CODE_LAST;

    // Source positions, the dead code 0 included
    localparam int NUM_SRC = `DSES_NUM_SRC;

    // The code map names exactly four completion sources
    if (NUM_CHAN != `DSES_NUM_CHAN) begin : g_bad_chan
        $error("dses_select: the code map serves exactly four channels");
    end

    // Every source position must be reachable by a code
    if (NUM_SRC > (1 << `DSES_CODE_W)) begin : g_bad_src
        $error("dses_select: more sources than codes");
    end

    // The event vector must line up with the source count
    if ($bits(dses_events_t) != NUM_SRC) begin : g_bad_vec
        $error("dses_select: event vector does not match the source count");
    end

    // One completion code per channel
    if ((`DSES_CODE_DONE3 - `DSES_CODE_DONE0 + 1) != NUM_CHAN) begin : g_bad_done
        $error("dses_select: completion codes do not match the channel count");
    end

    // The last named code must sit at the top of the source vector
    if (int'(LAST_CODE) != NUM_SRC - 1) begin : g_bad_last
        $error("dses_select: last code does not match the source count");
    end

    // True for a code that names a source, false for code 0 and the reserved top
    function automatic logic code_fires(input dses_code_t code);
        logic named;
        named = (code != `DSES_CODE_NONE) && (code <= LAST_CODE);
        return named;
    endfunction

    dses_events_t events;
    dses_sel_t [NUM_CHAN-1:0] sel_reg;
    dses_sel_t [NUM_CHAN-1:0] sel_next;
    dses_trig_t [NUM_CHAN-1:0] trig_reg;
    dses_trig_t [NUM_CHAN-1:0] trig_next;

    // Source vector, bit position equals the event code
    always_comb begin
        events = '0;

        // Code 0 is the dead slot
        events.never_fires = 1'b0;

        // Timers and the refresh timer
        events.timer0_expiry = timer0_expiry;
        events.timer1_expiry = timer1_expiry;
        events.refresh_timer_event = refresh_timer_event;

        // External interrupt pins
        events.ext_irq_pin_four = ext_irq_pin_four;
        events.ext_irq_pin_five = ext_irq_pin_five;
        events.ext_irq_pin_six = ext_irq_pin_six;
        events.ext_irq_pin_seven = ext_irq_pin_seven;

        // Channel completions; a channel that selects its own completion simply
        // retriggers once per finished block
        events.chan0_done = chan_done[0];
        events.chan1_done = chan_done[1];
        events.chan2_done = chan_done[2];
        events.chan3_done = chan_done[3];

        // Serial ports 0 and 1
        events.serial0_tx_event = serial0_tx_event;
        events.serial0_rx_event = serial0_rx_event;
        events.serial1_tx_event = serial1_tx_event;
        events.serial1_rx_event = serial1_rx_event;

        // Host doorbell
        events.host_doorbell = host_doorbell;

        // Serial port 2
        events.serial2_tx_event = serial2_tx_event;
        events.serial2_rx_event = serial2_rx_event;
    end

    // Selections are held so a trigger never glitches mid-write of the control word.
    // The cost is one extra cycle before a new code takes effect.
    always_comb begin
        sel_next = sel_reg;
        if (clk_en) begin
            sel_next = chan_sel;
        end
    end

    // Reset selects code 0 on every channel, so nothing triggers until a real
    // code is written
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= '0;
        end else begin
            sel_reg <= sel_next;
        end
    end

    logic [NUM_CHAN-1:0] rd_hit;
    logic [NUM_CHAN-1:0] wr_hit;
    logic [NUM_CHAN-1:0] rd_fire;
    logic [NUM_CHAN-1:0] wr_fire;

    // One read and one write selector per channel
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan

            // Read side
            dses_code_mux #(
                .NUM_SRC(NUM_SRC)
            ) u_rd (
                .code(sel_reg[ch].read_trigger_select),
                .events(events),
                .hit(rd_hit[ch])
            );

            // Write side, a separate selector so the two directions pick their sources independently, even the same one
            dses_code_mux #(
                .NUM_SRC(NUM_SRC)
            ) u_wr (
                .code(sel_reg[ch].write_trigger_select),
                .events(events),
                .hit(wr_hit[ch])
            );

            // Reserved codes are cut here as well as in the selector, so a longer
            // source list in the selector can never wake them
            assign rd_fire[ch] = rd_hit[ch]
                & code_fires(sel_reg[ch].read_trigger_select);
            assign wr_fire[ch] = wr_hit[ch]
                & code_fires(sel_reg[ch].write_trigger_select);
        end
    endgenerate

    // Triggers are registered so the transfer engine sees one clean level per cycle
    always_comb begin
        trig_next = trig_reg;
        if (clk_en) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                trig_next[i].read_trigger = rd_fire[i];
                trig_next[i].write_trigger = wr_fire[i];
            end
        end
    end

    // A low clock enable holds the last trigger levels rather than dropping them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trig_reg <= '0;
        end else begin
            trig_reg <= trig_next;
        end
    end

    assign chan_trig = trig_reg;

endmodule

`default_nettype wire

// ---- testbench/dses_chk_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module dses_chk
    import dses_pkg::*;
#(
    parameter int NUM_CHAN = 4
) (
    // Clock and selections
    input wire logic clock, rst_n, clk_en,
    input wire dses_sel_t [NUM_CHAN-1:0] chan_sel,
    // Event sources
    input wire logic timer0_expiry, timer1_expiry, refresh_timer_event, ext_irq_pin_four,
    input wire logic ext_irq_pin_five, ext_irq_pin_six, ext_irq_pin_seven, serial0_tx_event,
    input wire logic serial0_rx_event, serial1_tx_event, serial1_rx_event, host_doorbell,
    input wire logic serial2_tx_event, serial2_rx_event,
    input wire logic [NUM_CHAN-1:0] chan_done,
    // Triggers
    input wire dses_trig_t [NUM_CHAN-1:0] chan_trig
);
    logic [31:0] ev;
    dses_sel_t [NUM_CHAN-1:0] sel_reg;
    logic [NUM_CHAN-1:0] rd_exp, wr_exp, rd_now, wr_now;
    dses_code_t c0;
    // Upper bits stay zero so codes with no source can never match
    always_comb begin
        ev = {13'h0000, serial2_rx_event, serial2_tx_event, host_doorbell, serial1_rx_event,
            serial1_tx_event, serial0_rx_event, serial0_tx_event, chan_done, ext_irq_pin_seven,
            ext_irq_pin_six, ext_irq_pin_five, ext_irq_pin_four, refresh_timer_event,
            timer1_expiry, timer0_expiry, 1'b0};
        c0 = sel_reg[0].read_trigger_select;
        for (int i = 0; i < NUM_CHAN; i++) begin
            rd_exp[i] = ev[sel_reg[i].read_trigger_select];
            wr_exp[i] = ev[sel_reg[i].write_trigger_select];
            rd_now[i] = chan_trig[i].read_trigger;
            wr_now[i] = chan_trig[i].write_trigger;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= '0;
        end else if (clk_en) begin
            sel_reg <= chan_sel;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    read_route_a: assert property ($past(clk_en) |-> rd_now == $past(rd_exp))
        else $error("read trigger off its selected event");
    write_route_a: assert property ($past(clk_en) |-> wr_now == $past(wr_exp))
        else $error("write trigger off its selected event");
    freeze_hold_a: assert property (!$past(clk_en) |-> $stable(chan_trig))
        else $error("triggers moved while disabled");
    timer_pick_a: assert property ($past(clk_en) && $past(c0) == 5'h01
        |-> rd_now[0] == $past(timer0_expiry)) else $error("timer code misrouted");
    pin_five_a: assert property ($past(clk_en) && $past(c0) == 5'h05
        |-> rd_now[0] == $past(ext_irq_pin_five)) else $error("pin five misrouted");
    pin_seven_a: assert property ($past(clk_en) && $past(c0) == 5'h07
        |-> rd_now[0] == $past(ext_irq_pin_seven)) else $error("pin seven misrouted");
    done_three_a: assert property ($past(clk_en) && $past(c0) == 5'h0B
        |-> rd_now[0] == $past(chan_done[3])) else $error("channel done misrouted");
    reserved_quiet_a: assert property ($past(clk_en)
        && ($past(c0) == 5'h00 || $past(c0) > 5'h12)
        |-> !rd_now[0]) else $error("reserved code triggered");
endmodule
bind dses_select dses_chk #(.NUM_CHAN(NUM_CHAN)) dses_chk_i (.*);
`default_nettype wire

// ---- testbench/dses_src_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dses_src_model
    import dses_pkg::*;
(
    // Request from the bench
    input wire dses_code_t pick,
    input wire logic fire,
    // Event lines, bit index equals code
    output logic [18:0] ev
);
    // One source at a time, so a wrong route cannot hide behind a right one
    assign ev = fire ? 19'h00001 << pick : 19'h00000;
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h seen %h", n, e, s); end end
module tb
    import dses_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic fire = 1'b0;
    dses_code_t pick = 5'h00;
    dses_sel_t [3:0] chan_sel = '0;
    logic [18:0] e;
    dses_trig_t [3:0] chan_trig;
    int err_total = 0;
    int checked = 0;
    always #4 clock = ~clock;
    dses_src_model dses_src_model_i (.pick(pick), .fire(fire), .ev(e));
    dses_select #(.NUM_CHAN(4)) dses_select_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .chan_sel(chan_sel), .timer0_expiry(e[1]), .timer1_expiry(e[2]),
        .refresh_timer_event(e[3]), .ext_irq_pin_four(e[4]), .ext_irq_pin_five(e[5]),
        .ext_irq_pin_six(e[6]), .ext_irq_pin_seven(e[7]), .chan_done(e[11:8]),
        .serial0_tx_event(e[12]), .serial0_rx_event(e[13]), .serial1_tx_event(e[14]),
        .serial1_rx_event(e[15]), .host_doorbell(e[16]), .serial2_tx_event(e[17]),
        .serial2_rx_event(e[18]), .chan_trig(chan_trig));
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic route_sweep();
        dses_code_t w;
        logic [7:0] x;
        for (int c = 0; c < 32; c++) begin
            for (int ch = 0; ch < 4; ch++) begin
                w = 5'(c) ^ 5'h01;
                chan_sel = '0;
                chan_sel[ch] = '{write_trigger_select: w, read_trigger_select: 5'(c)};
                step();
                pick = 5'(c);
                fire = 1'b1;
                step();
                x = 8'(c > 0 && c < 19) << (2 * ch);
                `CHK("read", x, 8'(chan_trig))
                pick = w;
                step();
                x = 8'(w > 0 && w < 19) << (2 * ch + 1);
                `CHK("write", x, 8'(chan_trig))
                fire = 1'b0;
            end
        end
    endtask
    task automatic freeze_check();
        chan_sel = '0;
        chan_sel[2].read_trigger_select = 5'h10;
        step();
        clk_en = 1'b0;
        pick = 5'h10;
        fire = 1'b1;
        step();
        `CHK("frozen", 8'h00, 8'(chan_trig))
        clk_en = 1'b1;
        step();
        `CHK("doorbell", 8'h10, 8'(chan_trig))
        fire = 1'b0;
    endtask
    task automatic reset_mid();
        chan_sel = '0;
        chan_sel[1].read_trigger_select = 5'h01;
        pick = 5'h01;
        fire = 1'b1;
        step();
        step();
        `CHK("live", 8'h04, 8'(chan_trig))
        rst_n = 1'b0;
        #1;
        `CHK("in reset", 8'h00, 8'(chan_trig))
        step();
        rst_n = 1'b1;
        step();
        `CHK("after release", 8'h00, 8'(chan_trig))
        step();
        `CHK("reselected", 8'h04, 8'(chan_trig))
        fire = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        route_sweep();
        freeze_check();
        reset_mid();
        tally_and_finish();
    end
    // About three thousand two hundred ns of traffic, so this leaves a wide margin
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
